// [hw/dwr_pkg.sv]
// Purpose: Constants and carrier types for the wake-ready controller
// Assumes: Core clock at 250 MHz
// Notes: Configuration flag word is a plain input, not a register
package dwr_pkg;
    localparam int FLAG_W = 16;
    localparam int SELF_POWERED_BIT = 0;
    localparam int PIN_SEL_BIT = 12;
    localparam int POLARITY_BIT = 13;
    localparam int OUTPUT_TYPE_BIT = 14;
    localparam int INDICATION_BIT = 15;
    localparam logic [3:0] WAKE_READY_FIELD = 4'h7;
    localparam logic [1:0] WAKE_LOW_MIN = 2'h2;
    localparam logic [3:0] PULSE_CYCLES = 4'h8;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_WAKE_READY = 3'b010,
        ST_NORMAL = 3'b100
    } dwr_state_t;

    typedef struct packed {
        logic wakeFrame;
        logic wakePacket;
        logic linkChange;
        logic hostResume;
    } dwr_events_t;

    typedef struct packed {
        logic remoteWakeAllow;
        logic hostFeature;
        logic wakeOnFrameEn;
        logic wakeOnPacketEn;
        logic wakeOnLinkChangeEn;
    } dwr_enables_t;
endpackage : dwr_pkg

// [hw/dwr_wake_ctrl.sv]
// Purpose: Power-up wake controller with default wake-ready mode
// Assumes: Events come from core-clock logic; strap and wake pin are async
// Notes: Inactive level of the event pin follows the polarity flag outside wake-ready
`timescale 1ns/1ps
`default_nettype none
module dwr_wake_ctrl (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Pins
    input wire logic strapPin,
    input wire logic external_wake_in_n,
    // Configuration and events
    input wire logic [dwr_pkg::FLAG_W-1:0] configFlag,
    input wire dwr_pkg::dwr_enables_t enables,
    input wire dwr_pkg::dwr_events_t events,
    // Outputs
    output logic power_event_out,
    output logic powerEventOe,
    output logic usbEnable,
    output logic usbLinesOe,
    output logic phyEnable,
    output logic packetDetectEn,
    output logic wakeReadyActive
);
    logic [1:0] rstSync;
    logic rstn;
    logic strapS1, strapS2, wakeS1, wakeS2;
    logic [1:0] lowCount;
    logic pinPulse;
    logic strapLatched;
    // Marks when strapS2 holds a real pin sample rather than its reset value
    logic [1:0] strapFill;
    logic eventSet;
    dwr_pkg::dwr_state_t state;
    logic wakeEvent, wakeHit, modeOk, staticLevel, activeHigh;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) rstSync <= 2'h0;
        else rstSync <= {rstSync[0], 1'b1};
    end
    assign rstn = rstSync[1];

    // Two-flop synchronisers for pins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            strapS1 <= 1'b0;
            strapS2 <= 1'b0;
            wakeS1 <= 1'b1;
            wakeS2 <= 1'b1;
            strapFill <= 2'h0;
        end else if (clkEn) begin
            strapS1 <= strapPin;
            strapS2 <= strapS1;
            strapFill <= {strapFill[0], 1'b1};
            wakeS1 <= external_wake_in_n;
            wakeS2 <= wakeS1;
        end
    end

    // Pulse qualifies at its rising edge after two low cycles
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lowCount <= 2'h0;
            pinPulse <= 1'b0;
        end else if (clkEn) begin
            pinPulse <= wakeS2 && (lowCount >= dwr_pkg::WAKE_LOW_MIN);
            if (!wakeS2) lowCount <= (lowCount == 2'h3) ? lowCount : lowCount + 2'h1;
            else lowCount <= 2'h0;
        end
    end

    assign modeOk = configFlag[dwr_pkg::SELF_POWERED_BIT]
        && (configFlag[dwr_pkg::INDICATION_BIT -: 4] == dwr_pkg::WAKE_READY_FIELD);
    assign staticLevel = !configFlag[dwr_pkg::INDICATION_BIT];
    // Wake-ready forces high-active; normal follows the flag
    assign activeHigh = (state == dwr_pkg::ST_WAKE_READY)
        || configFlag[dwr_pkg::POLARITY_BIT];

    // Normal-mode wake sources
    assign wakeEvent = events.hostResume
        || (enables.remoteWakeAllow && enables.hostFeature
            && ((enables.wakeOnFrameEn && events.wakeFrame)
                || (enables.wakeOnPacketEn && events.wakePacket)
                || (enables.wakeOnLinkChangeEn && events.linkChange)
                || pinPulse));
    assign wakeHit = events.wakePacket || pinPulse;
    // One set term shared by the event flag and its checks
    assign eventSet = (state == dwr_pkg::ST_WAKE_READY && wakeHit)
        || (state == dwr_pkg::ST_NORMAL && wakeEvent);

    // Strap caught once, one clock after the synchroniser settles
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= dwr_pkg::ST_STRAP;
            strapLatched <= 1'b0;
        end else if (clkEn) begin
            unique case (state)
                dwr_pkg::ST_STRAP: begin
                    // Waiting keeps the synchroniser's reset value from choosing the mode
                    if (strapFill[1]) begin
                        strapLatched <= strapS2;
                        state <= (strapS2 && modeOk) ? dwr_pkg::ST_WAKE_READY
                                                     : dwr_pkg::ST_NORMAL;
                    end
                end
                dwr_pkg::ST_WAKE_READY: if (wakeHit) state <= dwr_pkg::ST_NORMAL;
                dwr_pkg::ST_NORMAL: state <= dwr_pkg::ST_NORMAL;
                default: state <= dwr_pkg::ST_STRAP;
            endcase
        end
    end

    logic asserted;
    logic [3:0] pulseCnt;
    // Static level sticks until reset; pulse mode times out
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            asserted <= 1'b0;
            pulseCnt <= 4'h0;
        end else if (clkEn) begin
            if (eventSet) begin
                asserted <= 1'b1;
                pulseCnt <= dwr_pkg::PULSE_CYCLES;
            end else if (!staticLevel && asserted) begin
                if (pulseCnt == 4'h0) asserted <= 1'b0;
                else pulseCnt <= pulseCnt - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_event_out <= 1'b0;
            powerEventOe <= 1'b0;
            usbEnable <= 1'b0;
            usbLinesOe <= 1'b0;
            phyEnable <= 1'b0;
            packetDetectEn <= 1'b0;
            wakeReadyActive <= 1'b0;
        end else if (clkEn) begin
            power_event_out <= activeHigh ? asserted : !asserted;
            powerEventOe <= configFlag[dwr_pkg::PIN_SEL_BIT];
            usbEnable <= (state == dwr_pkg::ST_NORMAL);
            usbLinesOe <= (state == dwr_pkg::ST_NORMAL);
            phyEnable <= (state != dwr_pkg::ST_STRAP);
            packetDetectEn <= (state != dwr_pkg::ST_STRAP);
            wakeReadyActive <= (state == dwr_pkg::ST_WAKE_READY);
        end
    end

    // Elaboration checks: the field compare needs four adjacent bits in the word
    if (dwr_pkg::INDICATION_BIT - dwr_pkg::PIN_SEL_BIT != 3
        || dwr_pkg::INDICATION_BIT >= dwr_pkg::FLAG_W) begin : g_field_check
        $error("Event flag field does not fit the flag word");
    end
    // A zero minimum would treat an idle pin as a finished pulse
    if (dwr_pkg::WAKE_LOW_MIN == 2'h0) begin : g_low_check
        $error("Wake pin minimum low time must be nonzero");
    end

    chk_lines_tristate: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_WAKE_READY |=> !usbLinesOe && !usbEnable)
        else $error("USB lines driven in wake-ready");
    chk_packet_wakes: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_WAKE_READY && events.wakePacket
        |=> asserted && state == dwr_pkg::ST_NORMAL)
        else $error("Wake packet missed");
    chk_static_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        asserted && staticLevel |=> asserted)
        else $error("Static event dropped");
    chk_strap_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_STRAP && strapFill[1] && !strapS2
        |=> state == dwr_pkg::ST_NORMAL)
        else $error("Low strap did not go normal");
    chk_self_power: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_STRAP && !configFlag[dwr_pkg::SELF_POWERED_BIT]
        |=> state != dwr_pkg::ST_WAKE_READY)
        else $error("Wake-ready without self power");
    chk_high_active: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_WAKE_READY |=> power_event_out == $past(asserted))
        else $error("Event polarity wrong");
    chk_pin_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && $rose(wakeS2) && lowCount >= dwr_pkg::WAKE_LOW_MIN |=> pinPulse)
        else $error("Pin pulse missed");
    chk_phy_on: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_WAKE_READY |=> phyEnable && packetDetectEn)
        else $error("PHY off in wake-ready");
    // A strap still high at the decision, with modeOk, must land in wake-ready
    chk_strap_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_STRAP && strapFill[1] && strapS2 && modeOk
        |=> state == dwr_pkg::ST_WAKE_READY && strapLatched)
        else $error("High strap did not enter wake-ready");
    chk_strap_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
        state == dwr_pkg::ST_STRAP && !strapFill[1] |=> state == dwr_pkg::ST_STRAP)
        else $error("Mode chosen before strap settled");
    chk_mode_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        state == dwr_pkg::ST_NORMAL |=> state == dwr_pkg::ST_NORMAL)
        else $error("Normal mode left before reset");
    chk_pin_short: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && $rose(wakeS2) && lowCount < dwr_pkg::WAKE_LOW_MIN |=> !pinPulse)
        else $error("Short pin pulse taken as wake");
    chk_usb_normal: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_NORMAL |=> usbEnable && usbLinesOe)
        else $error("USB off in normal mode");
    chk_host_resume: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_NORMAL && events.hostResume |=> asserted)
        else $error("Host resume ignored");
    chk_wake_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && state == dwr_pkg::ST_NORMAL && !asserted && !events.hostResume
        && !(enables.remoteWakeAllow && enables.hostFeature) |=> !asserted)
        else $error("Remote wake without allow and feature");
    chk_pulse_ends: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn && asserted && !staticLevel && pulseCnt == 4'h0 && !eventSet |=> !asserted)
        else $error("Pulse output did not end");
    chk_pin_routed: assert property (@(posedge ref_clk) disable iff (!rstn)
        clkEn |=> powerEventOe == $past(configFlag[dwr_pkg::PIN_SEL_BIT]))
        else $error("Event pin select not followed");
    chk_frozen_state: assert property (@(posedge ref_clk) disable iff (!rstn)
        !clkEn |=> $stable(state) && $stable(asserted))
        else $error("State moved with clock enable low");
endmodule : dwr_wake_ctrl
`default_nettype wire

// [tb/dwr_pmic_model.sv]
// Purpose: Power management IC stand-in facing the wake controller
// Assumes: Event output is an active-high static level
// Notes: Wake pin has a pull-up, so it idles high
`timescale 1ns/1ps
`default_nettype none
module dwr_pmic_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Device side
    input wire logic powerEvent,
    output logic wakeN,
    output logic hostPowered
);
    initial wakeN = 1'b1;
    // Supply latches on at the first event; a board reset drops it again
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) hostPowered <= 1'b0;
        else if (powerEvent === 1'b1) hostPowered <= 1'b1;
    end
    task automatic pulseWake(input int n);
        @(posedge ref_clk);
        wakeN <= 1'b0;
        repeat (n) @(posedge ref_clk);
        wakeN <= 1'b1;
    endtask : pulseWake
endmodule : dwr_pmic_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the wake-ready controller
// Assumes: Outputs settle one edge after their cause
// Notes: Outputs compared as one vector {event,oe,usb,lines,phy,pkt,ready}
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, resetn, clkEn, strapPin, wakeN, hostPowered;
    logic [15:0] configFlag;
    dwr_pkg::dwr_enables_t enables;
    dwr_pkg::dwr_events_t events;
    logic pe, peOe, usbEn, linesOe, phyEn, pktEn, wrAct;
    wire logic [6:0] outs = {pe, peOe, usbEn, linesOe, phyEn, pktEn, wrAct};
    int fails = 0;
    int checks = 0;
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    dwr_wake_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
        .strapPin(strapPin), .external_wake_in_n(wakeN), .configFlag(configFlag),
        .enables(enables), .events(events), .power_event_out(pe), .powerEventOe(peOe),
        .usbEnable(usbEn), .usbLinesOe(linesOe), .phyEnable(phyEn),
        .packetDetectEn(pktEn), .wakeReadyActive(wrAct));
    dwr_pmic_model pmic_u (.ref_clk(ref_clk), .resetn(resetn), .powerEvent(pe), .wakeN(wakeN),
        .hostPowered(hostPowered));
    task wrap_up();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic doReset(input logic strap, input logic [15:0] flag);
        @(posedge ref_clk);
        resetn <= 1'b0;
        strapPin <= strap;
        configFlag <= flag;
        enables <= '0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
    endtask : doReset
    task automatic pulse(input dwr_pkg::dwr_events_t ev);
        @(posedge ref_clk);
        events <= ev;
        @(posedge ref_clk);
        events <= '0;
    endtask : pulse
    // Bounded wait; a missing event shows up in the following compare
    task automatic wakeWait(input int n);
        for (int i = 0; i < n && pe !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wakeWait
    task automatic packetWake();
        doReset(1'b1, 16'h7001);
        check(outs, 7'h27);
        @(posedge ref_clk);
        strapPin <= 1'b0;
        pulse(4'b0100);
        wakeWait(12);
        check(outs, 7'h7e);
        repeat (30) @(posedge ref_clk);
        #1;
        check(outs, 7'h7e);
        check({6'h0, hostPowered}, 7'h01);
    endtask : packetWake
    task automatic pinWake();
        doReset(1'b1, 16'h7001);
        check(outs, 7'h27);
        pmic_u.pulseWake(1);
        repeat (10) @(posedge ref_clk);
        #1;
        check(outs, 7'h27);
        pmic_u.pulseWake(2);
        wakeWait(12);
        check(outs, 7'h7e);
    endtask : pinWake
    // Normal mode: frame and link-change wakes each need their own enable
    task automatic linkWake();
        doReset(1'b0, 16'h7001);
        @(posedge ref_clk);
        enables <= 5'b11001;
        pulse(4'b1000);
        repeat (6) @(posedge ref_clk);
        #1;
        check(outs, 7'h3e);
        pulse(4'b0010);
        wakeWait(12);
        check(outs, 7'h7e);
    endtask : linkWake
    // Pulse type and low-active pin in normal mode, woken by host resume
    task automatic pulseMode();
        doReset(1'b0, 16'h9001);
        check(outs, 7'h7e);
        pulse(4'b0001);
        @(posedge ref_clk);
        #1;
        check({6'h0, pe}, 7'h00);
        repeat (8) @(posedge ref_clk);
        #1;
        check({6'h0, pe}, 7'h00);
        @(posedge ref_clk);
        #1;
        check({6'h0, pe}, 7'h01);
    endtask : pulseMode
    task automatic normalWake();
        doReset(1'b0, 16'h7001);
        check(outs, 7'h3e);
        pulse(4'b0100);
        repeat (6) @(posedge ref_clk);
        #1;
        check(outs, 7'h3e);
        @(posedge ref_clk);
        enables <= 5'b11010;
        pulse(4'b0100);
        wakeWait(12);
        check({6'h0, pe}, 7'h01);
    endtask : normalWake
    task automatic badFlags();
        doReset(1'b1, 16'h7000);
        check(outs, 7'h3e);
        doReset(1'b1, 16'h6001);
        check(outs, 7'h1e);
    endtask : badFlags
    initial begin
        resetn = 1'b0;
        clkEn = 1'b1;
        strapPin = 1'b0;
        configFlag = 16'h0000;
        enables = '0;
        events = '0;
        packetWake();
        pinWake();
        normalWake();
        linkWake();
        pulseMode();
        badFlags();
        wrap_up();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
